// File: hdl/smq_move_sequencer.sv
// Stepper move sequencer with AXI4-Lite register slave
//
// Operation
// - Relative moves start even while the position is marked invalid.
// - Hold during a relative move decelerates to stop, then sets held.
// - Held move finishes on resume, or is dropped when another starts.
// - Resume reloads speed and ramp values but keeps the target.
// - Rising edge of the halt bit stops all motion at once.
// - Rising edge of the emergency-stop input stops the move at once.
// - Limit in travel direction stops; that direction refused until reset.
// - Limit opposite travel direction stops, no error reset needed.
// - Absolute move runs clockwise when target exceeds position.
// - Absolute moves only run while the position is valid.
// - Preset or completed homing marks the position valid.
// - Held absolute move resumes on continue or drops on new move.
// - Clockwise jog counts up, counter-clockwise down, while commanded.
// - Clearing the jog bit starts a controlled stop.
// - Rising edge of the jog stop input starts a controlled stop.
// - Jog may start on an active limit when heading away from it.
// - Jog starts at start speed and ramps to programmed speed.
// - Controlled jog stop ramps to start speed, position stays valid.
// - Immediate jog stop halts at once and invalidates position.
// - Jog follows new speed and ramp values while running.
// - Jog speed below start speed is ignored.
`timescale 1ns/1ps

module smq_move_sequencer import smq_pkg::*; #(
   parameter int SPD_W = 24
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Machine inputs, active high
   input wire logic cw_limit_in,
   input wire logic ccw_limit_in,
   input wire logic jog_stop_in,
   input wire logic estop_in,
   // Motor drive
   output logic step_out,
   output logic dir_cw_out
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [SPD_W-1:0] ramp(input logic [SPD_W-1:0] cur,
                                             input logic [SPD_W-1:0] tgt,
                                             input logic [SPD_W-1:0] acc,
                                             input logic [SPD_W-1:0] dec);
      logic [SPD_W:0] up;
      up = {1'b0, cur} + {1'b0, acc};
      if (cur < tgt) begin
         return (up > {1'b0, tgt}) ? tgt : up[SPD_W-1:0];
      end else if (cur > tgt) begin
         return ((cur - tgt) > dec) ? cur - dec : tgt;
      end
      return cur;
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   wire [3:0] pin_raw = {estop_in, jog_stop_in, ccw_limit_in, cw_limit_in};
   wire [3:0] pin_rise = pin_s2 & ~pin_s3;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         pin_s3 <= 4'h0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic aw_rdy, w_rdy, aw_got, w_got, b_vld, ar_rdy, r_vld;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data;

   wire aw_take = s_axi_awvalid_in && aw_rdy;
   wire w_take = s_axi_wvalid_in && w_rdy;
   wire do_write = aw_got && w_got && !b_vld;
   wire b_done = b_vld && s_axi_bready_in;
   wire ar_take = s_axi_arvalid_in && ar_rdy;
   wire r_done = r_vld && s_axi_rready_in;

   wire wr_ctrl = do_write && (aw_addr == REG_CTRL);
   wire wr_tgt = do_write && (aw_addr == REG_TARGET);
   wire wr_spd = do_write && (aw_addr == REG_SPEED);
   wire wr_sspd = do_write && (aw_addr == REG_START_SPD);
   wire wr_acc = do_write && (aw_addr == REG_ACCEL);
   wire wr_dec = do_write && (aw_addr == REG_DECEL);
   wire wr_pre = do_write && (aw_addr == REG_PRESET);
   wire wr_prof = do_write && (aw_addr == REG_PROFILE);
   wire wr_hit = wr_ctrl || wr_tgt || wr_spd || wr_sspd || wr_acc ||
                 wr_dec || wr_pre || wr_prof;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_rdy <= 1'b0;
         w_rdy <= 1'b0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         b_vld <= 1'b0;
         b_resp <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         aw_rdy <= !(aw_got || aw_take) && !(b_vld && !b_done);
         w_rdy <= !(w_got || w_take) && !(b_vld && !b_done);
         if (aw_take) begin
            aw_got <= 1'b1;
            aw_addr <= {s_axi_awaddr_in[7:2], 2'h0};
         end
         if (w_take) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            b_vld <= 1'b1;
            b_resp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            b_vld <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Host registers
   // ------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_lvl;
   logic [CTRL_W-1:0] cmd;
   logic [23:0] target_r;
   logic [SPD_W-1:0] speed_r, start_spd_r, accel_r, decel_r;
   logic [31:0] preset_r;
   logic [3:0] profile_r;
   wire [31:0] ctrl_new = merge({22'h000000, ctrl_lvl}, w_data, w_strb);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_lvl <= '0;
         cmd <= '0;
         target_r <= 24'h000000;
         speed_r <= '0;
         start_spd_r <= '0;
         accel_r <= '0;
         decel_r <= '0;
         preset_r <= 32'h00000000;
         profile_r <= 4'h0;
      end else begin
         cmd <= wr_ctrl ? ctrl_new[CTRL_W-1:0] : '0;
         if (wr_ctrl) begin
            ctrl_lvl <= ctrl_new[CTRL_W-1:0];
         end
         if (wr_tgt) begin
            target_r <= 24'(merge({8'h00, target_r}, w_data, w_strb));
         end
         if (wr_spd) begin
            speed_r <= SPD_W'(merge(32'(speed_r), w_data, w_strb));
         end
         if (wr_sspd) begin
            start_spd_r <= SPD_W'(merge(32'(start_spd_r), w_data, w_strb));
         end
         if (wr_acc) begin
            accel_r <= SPD_W'(merge(32'(accel_r), w_data, w_strb));
         end
         if (wr_dec) begin
            decel_r <= SPD_W'(merge(32'(decel_r), w_data, w_strb));
         end
         if (wr_pre) begin
            preset_r <= merge(preset_r, w_data, w_strb);
         end
         if (wr_prof) begin
            profile_r <= 4'(merge({28'h0000000, profile_r}, w_data, w_strb));
         end
      end
   end

   // ------------------------------------------------------------
   // Motion state
   // ------------------------------------------------------------
   smq_state_t state, next_state;
   smq_kind_t kind, next_kind;
   logic dir_q, next_dir;
   logic [SPD_W-1:0] cur_spd, next_cur, spd_l, next_spd_l;
   logic [SPD_W-1:0] acc_l, next_acc_l, dec_l, next_dec_l, jog_spd;
   logic [3:0] prof_l, next_prof_l;
   logic [24:0] remaining, next_rem, ramp_steps, next_ramp;
   logic [31:0] pos, next_pos;
   logic pos_inv, next_inv, cw_err, next_cw_err, ccw_err, next_ccw_err;
   logic hold_stop, next_hold_stop, step_q, next_step;
   logic [SPD_W-1:0] phase, next_phase;
   logic [7:0] ramp_cnt;
   logic halt_q;
   logic [1:0] jog_q;

   wire moving = (state == ST_RUN) || (state == ST_DECEL);
   wire can_start = (state == ST_IDLE) || (state == ST_HELD);
   wire ramp_tick = (ramp_cnt == 8'(RAMP_TICK_CYC - 1));
   wire halt_rise = ctrl_lvl[CB_HALT] && !halt_q;
   wire cw_hit = moving && pin_rise[PIN_CW];
   wire ccw_hit = moving && pin_rise[PIN_CCW];
   wire imm_stop = moving && (halt_rise || pin_rise[PIN_ESTOP] ||
                   cw_hit || ccw_hit);
   wire jog_cw_rise = ctrl_lvl[CB_JOG_CW] && !jog_q[0];
   wire jog_ccw_rise = ctrl_lvl[CB_JOG_CCW] && !jog_q[1];
   wire jog_cleared = dir_q ? !ctrl_lvl[CB_JOG_CW] : !ctrl_lvl[CB_JOG_CCW];
   wire jog_ctl_stop = (kind == MV_JOG) && (jog_cleared ||
                       pin_rise[PIN_STOP] || cmd[CB_HOLD]);
   wire pos_ctl_stop = (kind != MV_JOG) && cmd[CB_HOLD];

   // Blocked directions: latched limit error or limit input held active
   wire cw_block = cw_err || pin_s2[PIN_CW];
   wire ccw_block = ccw_err || pin_s2[PIN_CCW];

   wire [31:0] tgt_ext = {{8{target_r[23]}}, target_r};
   wire [32:0] abs_diff = {tgt_ext[31], tgt_ext} - {pos[31], pos};
   wire abs_cw = $signed(tgt_ext) > $signed(pos);
   wire [24:0] abs_dist = abs_cw ? abs_diff[24:0] : 25'(-abs_diff);
   wire [24:0] rel_dist = target_r[23] ? 25'(-{1'b1, target_r}) :
                          {1'b0, target_r};
   wire tgt_ok = (target_r != TARGET_MOST_NEG);
   wire rel_ok = tgt_ok && (rel_dist != 25'h0000000) &&
                 (target_r[23] ? !ccw_block : !cw_block);
   wire abs_ok = tgt_ok && !pos_inv && (abs_dist != 25'h0000000) &&
                 (abs_cw ? !cw_block : !ccw_block);
   wire go_rel = can_start && cmd[CB_REL] && rel_ok;
   wire go_abs = can_start && cmd[CB_ABS] && abs_ok;
   wire go_jcw = can_start && jog_cw_rise && !cw_block;
   wire go_jccw = can_start && jog_ccw_rise && !ccw_block;
   wire go_any = go_rel || go_abs || go_jcw || go_jccw;

   // Jog speed floor is the starting speed
   wire [SPD_W-1:0] jog_tgt = (jog_spd < start_spd_r) ? start_spd_r : jog_spd;
   wire [SPD_W-1:0] run_tgt = (kind == MV_JOG) ? jog_tgt : spd_l;
   wire [SPD_W-1:0] use_tgt = (state == ST_DECEL) ? start_spd_r : run_tgt;
   wire [SPD_W-1:0] use_acc = (kind == MV_JOG) ? accel_r : acc_l;
   wire [SPD_W-1:0] use_dec = (kind == MV_JOG) ? decel_r : dec_l;
   wire [SPD_W-1:0] ramped = ramp(cur_spd, use_tgt, use_acc, use_dec);
   wire [SPD_W:0] phase_sum = {1'b0, phase} + {1'b0, cur_spd};
   wire step_now = moving && phase_sum[SPD_W] &&
                   ((kind == MV_JOG) || (remaining != 25'h0000000));

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_dir = dir_q;
      next_cur = cur_spd;
      next_rem = remaining;
      next_ramp = ramp_steps;
      next_pos = pos;
      next_inv = pos_inv;
      next_cw_err = cw_err;
      next_ccw_err = ccw_err;
      next_hold_stop = hold_stop;
      next_spd_l = spd_l;
      next_acc_l = acc_l;
      next_dec_l = dec_l;
      next_prof_l = prof_l;
      next_phase = moving ? phase_sum[SPD_W-1:0] : '0;
      next_step = 1'b0;
      if (cmd[CB_RST_ERR]) begin
         next_cw_err = 1'b0;
         next_ccw_err = 1'b0;
      end
      if (moving && ramp_tick) begin
         next_cur = ramped;
      end
      if (step_now) begin
         next_step = 1'b1;
         next_pos = dir_q ? pos + 32'h00000001 : pos - 32'h00000001;
         if (kind != MV_JOG) begin
            next_rem = remaining - 25'h0000001;
         end
         if ((state == ST_RUN) && (cur_spd < use_tgt)) begin
            next_ramp = ramp_steps + 25'h0000001;
         end else if ((state == ST_DECEL) && (ramp_steps != 25'h0000000)) begin
            next_ramp = ramp_steps - 25'h0000001;
         end
      end
      if (imm_stop) begin
         next_state = ST_IDLE;
         next_cur = '0;
         next_inv = 1'b1;
         if (cw_hit && dir_q) begin
            next_cw_err = 1'b1;
         end
         if (ccw_hit && !dir_q) begin
            next_ccw_err = 1'b1;
         end
      end else if (moving) begin
         if ((state == ST_RUN) && (jog_ctl_stop || pos_ctl_stop)) begin
            next_state = ST_DECEL;
            next_hold_stop = pos_ctl_stop;
         end else if ((state == ST_RUN) && (kind != MV_JOG) &&
                      (remaining <= ramp_steps)) begin
            next_state = ST_DECEL;
            next_hold_stop = 1'b0;
         end
         if ((kind != MV_JOG) && step_now && (remaining == 25'h0000001)) begin
            next_state = ST_IDLE;
            next_cur = '0;
         end else if ((state == ST_DECEL) && (cur_spd <= start_spd_r) &&
                      ((kind == MV_JOG) || hold_stop)) begin
            next_state = (kind == MV_JOG) ? ST_IDLE : ST_HELD;
            next_cur = '0;
         end
      end else if (go_any) begin
         next_state = ST_RUN;
         next_kind = go_rel ? MV_REL : (go_abs ? MV_ABS : MV_JOG);
         next_dir = go_rel ? !target_r[23] : (go_abs ? abs_cw : go_jcw);
         next_rem = go_rel ? rel_dist : abs_dist;
         next_cur = start_spd_r;
         next_ramp = 25'h0000000;
         next_hold_stop = 1'b0;
         next_spd_l = speed_r;
         next_acc_l = accel_r;
         next_dec_l = decel_r;
         next_prof_l = profile_r;
      end else if ((state == ST_HELD) && cmd[CB_RESUME]) begin
         next_state = ST_RUN;
         next_cur = start_spd_r;
         next_ramp = 25'h0000000;
         next_hold_stop = 1'b0;
         next_spd_l = speed_r;
         next_acc_l = accel_r;
         next_dec_l = decel_r;
         next_prof_l = profile_r;
      end else if (cmd[CB_PRESET]) begin
         next_pos = preset_r;
         next_inv = 1'b0;
      end else if (cmd[CB_HOMED]) begin
         next_inv = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         kind <= MV_REL;
         dir_q <= 1'b1;
         cur_spd <= '0;
         remaining <= 25'h0000000;
         ramp_steps <= 25'h0000000;
         pos <= 32'h00000000;
         pos_inv <= POS_INVALID_RST;
         cw_err <= 1'b0;
         ccw_err <= 1'b0;
         hold_stop <= 1'b0;
         spd_l <= '0;
         acc_l <= '0;
         dec_l <= '0;
         prof_l <= 4'h0;
         phase <= '0;
         step_q <= 1'b0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         dir_q <= next_dir;
         cur_spd <= next_cur;
         remaining <= next_rem;
         ramp_steps <= next_ramp;
         pos <= next_pos;
         pos_inv <= next_inv;
         cw_err <= next_cw_err;
         ccw_err <= next_ccw_err;
         hold_stop <= next_hold_stop;
         spd_l <= next_spd_l;
         acc_l <= next_acc_l;
         dec_l <= next_dec_l;
         prof_l <= next_prof_l;
         phase <= next_phase;
         step_q <= next_step;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ramp_cnt <= 8'h00;
         halt_q <= 1'b0;
         jog_q <= 2'h0;
         jog_spd <= '0;
      end else begin
         ramp_cnt <= (ramp_tick || !moving) ? 8'h00 : ramp_cnt + 8'h01;
         halt_q <= ctrl_lvl[CB_HALT];
         jog_q <= {ctrl_lvl[CB_JOG_CCW], ctrl_lvl[CB_JOG_CW]};
         if (speed_r >= start_spd_r) begin
            jog_spd <= speed_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   wire [31:0] status_w = {20'h00000, prof_l, ccw_err, cw_err, dir_q,
                           (kind == MV_JOG), pos_inv, (state == ST_HELD),
                           (state == ST_DECEL), moving};
   wire ar_hit = (s_axi_araddr_in[7:2] <= REG_CUR_SPD[7:2]);
   logic [31:0] rd_mux;

   always_comb begin
      unique case ({s_axi_araddr_in[7:2], 2'h0})
         REG_CTRL: rd_mux = {22'h000000, ctrl_lvl};
         REG_TARGET: rd_mux = tgt_ext;
         REG_SPEED: rd_mux = 32'(speed_r);
         REG_START_SPD: rd_mux = 32'(start_spd_r);
         REG_ACCEL: rd_mux = 32'(accel_r);
         REG_DECEL: rd_mux = 32'(decel_r);
         REG_PRESET: rd_mux = preset_r;
         REG_PROFILE: rd_mux = {28'h0000000, profile_r};
         REG_STATUS: rd_mux = status_w;
         REG_POSITION: rd_mux = pos;
         REG_CUR_SPD: rd_mux = 32'(cur_spd);
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ar_rdy <= 1'b0;
         r_vld <= 1'b0;
         r_data <= 32'h00000000;
         r_resp <= RESP_OKAY;
      end else begin
         ar_rdy <= !ar_take && !(r_vld && !r_done);
         if (ar_take) begin
            r_vld <= 1'b1;
            r_data <= rd_mux;
            r_resp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (r_done) begin
            r_vld <= 1'b0;
         end
      end
   end

   assign s_axi_awready_out = aw_rdy;
   assign s_axi_wready_out = w_rdy;
   assign s_axi_bvalid_out = b_vld;
   assign s_axi_bresp_out = b_resp;
   assign s_axi_arready_out = ar_rdy;
   assign s_axi_rvalid_out = r_vld;
   assign s_axi_rdata_out = r_data;
   assign s_axi_rresp_out = r_resp;
   assign step_out = step_q;
   assign dir_cw_out = dir_q;

endmodule

// File: hdl/smq_pkg.sv
// Constants and types shared by the stepper move sequencer
package smq_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TARGET = 8'h04;
   localparam logic [7:0] REG_SPEED = 8'h08;
   localparam logic [7:0] REG_START_SPD = 8'h0C;
   localparam logic [7:0] REG_ACCEL = 8'h10;
   localparam logic [7:0] REG_DECEL = 8'h14;
   localparam logic [7:0] REG_PRESET = 8'h18;
   localparam logic [7:0] REG_PROFILE = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_POSITION = 8'h24;
   localparam logic [7:0] REG_CUR_SPD = 8'h28;

   // ------------------------------------------------------------
   // Control word bits
   // ------------------------------------------------------------
   localparam int CB_REL = 0;
   localparam int CB_ABS = 1;
   localparam int CB_JOG_CW = 2;
   localparam int CB_JOG_CCW = 3;
   localparam int CB_HOLD = 4;
   localparam int CB_RESUME = 5;
   localparam int CB_HALT = 6;
   localparam int CB_RST_ERR = 7;
   localparam int CB_PRESET = 8;
   localparam int CB_HOMED = 9;
   localparam int CTRL_W = 10;

   // ------------------------------------------------------------
   // Input pin order after synchronising
   // ------------------------------------------------------------
   localparam int PIN_CW = 0;
   localparam int PIN_CCW = 1;
   localparam int PIN_STOP = 2;
   localparam int PIN_ESTOP = 3;

   // ------------------------------------------------------------
   // Bus answers, limits, reset values, timing
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [23:0] TARGET_MOST_NEG = 24'h800000;
   localparam logic POS_INVALID_RST = 1'b1;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int RAMP_PERIOD_NS = 1000;
   localparam int RAMP_TICK_CYC = (RAMP_PERIOD_NS * CLK_FREQ_MHZ) / 1000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_DECEL,
      ST_HELD
   } smq_state_t;

   typedef enum logic [1:0] {
      MV_REL,
      MV_ABS,
      MV_JOG
   } smq_kind_t;

endpackage

// File: verification/smq_monitor.sv
// Port checker for the move sequencer
`timescale 1ns/1ps
module smq_monitor (
   input wire logic ref_clk_in, rst_n_in,
   input wire logic s_axi_awvalid_in, s_axi_awready_out,
   input wire logic s_axi_wvalid_in, s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out, s_axi_bready_in,
   input wire logic s_axi_arvalid_in, s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out, s_axi_rready_in,
   input wire logic cw_limit_in, ccw_limit_in, estop_in,
   input wire logic step_out, dir_cw_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_b_latency: assert property (s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write response late");
   chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   chk_r_latency: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out) else $error("read data late");
   chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
   chk_estop_halts: assert property ($rose(estop_in) |-> ##6 !step_out[*8])
      else $error("steps after emergency stop");
   chk_limit_halts: assert property
      ($rose(cw_limit_in) || $rose(ccw_limit_in) |-> ##6 !step_out[*8])
      else $error("steps after limit");
   chk_cw_blocked: assert property (cw_limit_in[*8]
      |-> !(step_out && dir_cw_out)) else $error("step into cw limit");
   chk_ccw_blocked: assert property (ccw_limit_in[*8]
      |-> !(step_out && !dir_cw_out)) else $error("step into ccw limit");
endmodule
bind smq_move_sequencer smq_monitor u_mon (.*);

// File: verification/smq_machine.sv
// Machine-side model counting motor steps
`timescale 1ns/1ps
module smq_machine (
   input wire logic clk_in,
   input wire logic step_in,
   input wire logic dir_cw_in,
   output logic signed [31:0] pos_out,
   output logic quiet_out
);
   logic [8:0] idle = 9'h0;
   initial pos_out = 0;
   assign quiet_out = idle == 9'h12C;
   always @(posedge clk_in) begin
      if (step_in) pos_out <= dir_cw_in ? pos_out + 1 : pos_out - 1;
      idle <= step_in ? 9'h0 : (quiet_out ? idle : idle + 9'h1);
   end
endmodule

// File: verification/smq_move_sequencer_tb.sv
// Self-checking bench for the move sequencer
`timescale 1ns/1ps
module smq_move_sequencer_tb import smq_pkg::*; ;
   logic ref_clk_in = 0, rst_n_in = 0;
   logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
   logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, jog_stop_in = 0;
   logic cw_limit_in = 0, ccw_limit_in = 0, estop_in = 0, quiet;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, step_out;
   logic s_axi_arready_out, s_axi_rvalid_out, dir_cw_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic signed [31:0] pos;
   logic [67:0] e, exp_q[$];
   int miscompares = 0, checks = 0, pv, n, b;
   smq_move_sequencer u_dut (.*);
   smq_machine u_mach (.clk_in(ref_clk_in), .step_in(step_out),
      .dir_cw_in(dir_cw_out), .pos_out(pos), .quiet_out(quiet));
   initial forever #2.5 ref_clk_in = ~ref_clk_in;
   task automatic check(input logic [33:0] got, exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h3;
      do begin
         @(posedge ref_clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 0;
      end while (s_axi_awvalid_in || s_axi_wvalid_in);
      while (!s_axi_bvalid_out) @(posedge ref_clk_in);
      s_axi_bready_in <= 1;
      @(posedge ref_clk_in);
      s_axi_bready_in <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] m, x);
      exp_q.push_back({m, x});
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1;
      do @(posedge ref_clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 0;
      while (!s_axi_rvalid_out) @(posedge ref_clk_in);
      s_axi_rready_in <= 1;
      @(posedge ref_clk_in);
      s_axi_rready_in <= 0;
   endtask
   task automatic settle;
      repeat (40) @(posedge ref_clk_in);
      wait (quiet);
      @(posedge ref_clk_in);
   endtask
   task automatic go(input logic [31:0] d);
      wr(REG_CTRL, d);
      settle;
   endtask
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Scoreboard: oldest read expectation against each read beat
   always @(posedge ref_clk_in) begin
      if (s_axi_rvalid_out && s_axi_rready_in && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check({s_axi_rresp_out, s_axi_rdata_out} & e[67:34], e[33:0]);
      end
   end
   initial begin
      #400000;
      miscompares++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hAA14));
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1;
      @(posedge ref_clk_in);
      rd(REG_STATUS, 34'h300000009, 34'h8);
      rd(8'h30, 34'h3FFFFFFFF, {RESP_SLVERR, 32'h0});
      wr(REG_SPEED, 32'h200000);
      wr(REG_START_SPD, 32'h100000);
      wr(REG_ACCEL, 32'h10000);
      wr(REG_DECEL, 32'h10000);
      wr(REG_TARGET, 32'h64);
      go(32'h2);
      rd(REG_POSITION, 34'h3FFFFFFFF, 34'h0);
      n = 10 + $urandom % 40;
      wr(REG_TARGET, n);
      go(32'h1);
      rd(REG_POSITION, 34'h3FFFFFFFF, 34'(n));
      pv = $urandom % 1000;
      wr(REG_PRESET, pv);
      go(32'h100);
      rd(REG_STATUS, 34'h300000009, 34'h0);
      wr(REG_TARGET, 32'hC8);
      b = pos;
      wr(REG_CTRL, 32'h1);
      wait (pos >= b + 20);
      @(posedge ref_clk_in);
      go(32'h10);
      rd(REG_STATUS, 34'h300000004, 34'h4);
      wr(REG_TARGET, 32'h5);
      wr(REG_SPEED, 32'h180000);
      go(32'h20);
      rd(REG_POSITION, 34'h3FFFFFFFF, 34'(pv + 200));
      n = 10 + $urandom % 40;
      wr(REG_TARGET, pv + 200 - n);
      go(32'h2);
      rd(REG_POSITION, 34'h3FFFFFFFF, 34'(pv + 200 - n));
      rd(REG_STATUS, 34'h300000020, 34'h0);
      ccw_limit_in <= 1;
      b = pos;
      wr(REG_CTRL, 32'h4);
      wait (pos >= b + 10);
      @(posedge ref_clk_in);
      go(32'h0);
      rd(REG_STATUS, 34'h300000019, 34'h10);
      ccw_limit_in <= 0;
      b = pos;
      wr(REG_CTRL, 32'h8);
      wait (pos <= b - 5);
      @(posedge ref_clk_in);
      estop_in <= 1;
      settle;
      rd(REG_STATUS, 34'h300000009, 34'h8);
      estop_in <= 0;
      b = pos;
      wr(REG_TARGET, 32'h64);
      wr(REG_CTRL, 32'h1);
      wait (pos >= b + 5);
      @(posedge ref_clk_in);
      cw_limit_in <= 1;
      repeat (10) @(posedge ref_clk_in);
      cw_limit_in <= 0;
      settle;
      rd(REG_STATUS, 34'h300000049, 34'h48);
      b = pos;
      go(32'h1);
      check(34'(pos), 34'(b));
      go(32'h80);
      rd(REG_STATUS, 34'h300000040, 34'h0);
      go(32'h200);
      b = pos;
      wr(REG_CTRL, 32'h8);
      wait (pos <= b - 5);
      @(posedge ref_clk_in);
      jog_stop_in <= 1;
      settle;
      rd(REG_STATUS, 34'h300000009, 34'h0);
      wr(REG_CTRL, 32'h4);
      repeat (100) @(posedge ref_clk_in);
      go(32'h44);
      rd(REG_STATUS, 34'h300000009, 34'h8);
      settle;
      wrap_up;
   end
endmodule
